// ### core/fts_pkg.sv
// ============================================================
// shared constants of the flow-through burst sram control
package fts_pkg;
  // array geometry
  localparam int unsigned ADDR_W     = 17;
  localparam int unsigned WORDS      = 131072;
  localparam int unsigned LANES      = 4;
  localparam int unsigned LANE_BITS  = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_W     = 36;
  localparam int unsigned PAR_BASE   = 32;
  localparam int unsigned BURST_W    = 2;
  // write buffer
  localparam int unsigned WBUF_DEPTH = 4;
  localparam int unsigned WBUF_W     = 57;
  // positions inside the synchronised pin vector
  localparam int unsigned PIN_W      = 66;
  localparam int unsigned P_ADDR     = 0;
  localparam int unsigned P_SEL_A_N  = 17;
  localparam int unsigned P_SEL_B    = 18;
  localparam int unsigned P_SEL_C_N  = 19;
  localparam int unsigned P_WSTB_N   = 20;
  localparam int unsigned P_LANE_N   = 21;
  localparam int unsigned P_ADV      = 25;
  localparam int unsigned P_CQ_N     = 26;
  localparam int unsigned P_ODRV_N   = 27;
  localparam int unsigned P_SLEEP    = 28;
  localparam int unsigned P_ORDER    = 29;
  localparam int unsigned P_DATA     = 30;
  localparam int unsigned P_PAR      = 62;
  // reset values
  localparam logic [PIN_W-1:0]   PIN_RST   = 66'h0;
  localparam logic [BURST_W-1:0] STEP_RST  = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 17'h0;
  localparam logic [WORD_W-1:0]  WORD_RST  = 36'h0;
endpackage : fts_pkg

// ### core/fts_sram_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// write buffer
module fts_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = slot_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      slot_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : fts_fifo

// ============================================================
// sram control top
module fts_sram_ctrl
  import fts_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              select_a_n_i,
  input  wire logic              select_b_i,
  input  wire logic              select_c_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic [LANES-1:0]  lane_write_n_i,
  input  wire logic              advance_or_load_i,
  input  wire logic              clock_qualify_n_i,
  input  wire logic              output_drive_n_i,
  input  wire logic              sleep_request_i,
  input  wire logic              burst_order_i,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe_o,
  input  wire logic [LANES-1:0]  parity_lines_i,
  output logic      [LANES-1:0]  parity_lines_o,
  output logic                   parity_lines_oe_o,
  output logic                   write_buffer_ready_o
);
  // ============================================================
  // pin synchronisers
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_q;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pin_s1_q <= PIN_RST;
      pin_q    <= PIN_RST;
    end else begin
      pin_s1_q <= {parity_lines_i, data_lines_i, burst_order_i, sleep_request_i, output_drive_n_i,
                   clock_qualify_n_i, advance_or_load_i, lane_write_n_i, write_strobe_n_i,
                   select_c_n_i, select_b_i, select_a_n_i, addr_i};
      pin_q    <= pin_s1_q;
    end
  end

  logic [ADDR_W-1:0] in_addr;
  logic [LANES-1:0]  in_lane_n;
  logic [DATA_W-1:0] in_data;
  logic [LANES-1:0]  in_par;
  logic              in_wstb_n;
  logic              in_adv;
  logic              in_odrv_n;
  logic              in_sleep;
  logic              in_order;
  logic              run;
  logic              selected;
  assign in_addr   = pin_q[P_ADDR +: ADDR_W];
  assign in_lane_n = pin_q[P_LANE_N +: LANES];
  assign in_data   = pin_q[P_DATA +: DATA_W];
  assign in_par    = pin_q[P_PAR +: LANES];
  assign in_wstb_n = pin_q[P_WSTB_N];
  assign in_adv    = pin_q[P_ADV];
  assign in_odrv_n = pin_q[P_ODRV_N];
  assign in_sleep  = pin_q[P_SLEEP];
  assign in_order  = pin_q[P_ORDER];
  // a suspended edge is simply not a run edge
  assign run       = !pin_q[P_CQ_N];
  assign selected  = !pin_q[P_SEL_A_N] && pin_q[P_SEL_B] && !pin_q[P_SEL_C_N];

  // ============================================================
  // access and burst registers
  logic [ADDR_W-1:0]  acc_addr_q;
  logic [BURST_W-1:0] seed_q;
  logic [BURST_W-1:0] step_q;
  logic [BURST_W-1:0] step_d;
  logic [BURST_W-1:0] offs_d;
  logic               op_q;
  logic               wr_q;
  logic [LANES-1:0]   lanes_q;

  assign step_d = step_q + 1'b1;
  assign offs_d = in_order ? (seed_q ^ step_d) : (seed_q + step_d);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      acc_addr_q <= ADDR_RST;
      seed_q     <= STEP_RST;
      step_q     <= STEP_RST;
      op_q       <= 1'b0;
      wr_q       <= 1'b0;
      lanes_q    <= '0;
    end else if (run) begin
      lanes_q <= ~in_lane_n;
      if (!in_adv) begin
        op_q       <= selected && !in_sleep;
        wr_q       <= !in_wstb_n;
        acc_addr_q <= in_addr;
        seed_q     <= in_addr[BURST_W-1:0];
        step_q     <= STEP_RST;
      end else begin
        // a burst keeps the access type of its load cycle
        op_q       <= op_q && !in_sleep;
        step_q     <= step_d;
        acc_addr_q <= {acc_addr_q[ADDR_W-1:BURST_W], offs_d};
      end
    end
  end

  // ============================================================
  // write path: data follows the address by one clock
  logic                   push_en;
  logic                   wbuf_ready;
  logic                   wbuf_valid;
  logic [WBUF_W-1:0]      wbuf_out;
  logic [ADDR_W-1:0]      wq_addr;
  logic [LANES-1:0]       wq_lanes;
  logic [WORD_W-1:0]      wq_word;
  logic                   mem_we;
  logic [WORD_W-1:0]      mem_q [WORDS];

  // a full buffer drops the beat; write_buffer_ready_o warns the source
  assign push_en  = run && op_q && wr_q;
  assign wq_addr  = wbuf_out[WORD_W+LANES +: ADDR_W];
  assign wq_lanes = wbuf_out[WORD_W +: LANES];
  assign wq_word  = wbuf_out[WORD_W-1:0];
  // drain pauses in sleep so the array sees no activity
  assign mem_we   = wbuf_valid && !in_sleep;

  fts_fifo #(
    .WIDTH (WBUF_W),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push_en),
    .in_ready_o  (wbuf_ready),
    .in_data_i   ({acc_addr_q, lanes_q, in_par, in_data}),
    .out_valid_o (wbuf_valid),
    .out_ready_i (!in_sleep),
    .out_data_o  (wbuf_out)
  );

  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      for (int i = 0; i < LANES; i++) begin
        if (wq_lanes[i]) begin
          mem_q[wq_addr][i*LANE_BITS +: LANE_BITS] <= wq_word[i*LANE_BITS +: LANE_BITS];
          mem_q[wq_addr][PAR_BASE+i]               <= wq_word[PAR_BASE+i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      write_buffer_ready_o <= 1'b0;
    end else begin
      write_buffer_ready_o <= wbuf_ready;
    end
  end

  // ============================================================
  // read path and output drive
  // limitation: a read right behind a write to the same word may see old data
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      data_lines_o   <= '0;
      parity_lines_o <= '0;
    end else if (run && op_q && !wr_q) begin
      data_lines_o   <= mem_q[acc_addr_q][DATA_W-1:0];
      parity_lines_o <= mem_q[acc_addr_q][PAR_BASE +: LANES];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      data_lines_oe_o   <= 1'b0;
      parity_lines_oe_o <= 1'b0;
    end else if (run) begin
      data_lines_oe_o   <= op_q && !wr_q && !in_odrv_n && !in_sleep;
      parity_lines_oe_o <= op_q && !wr_q && !in_odrv_n && !in_sleep;
    end
  end

  // ============================================================
  // checks
  a_suspend_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !run |=> $stable(acc_addr_q) && $stable(step_q) && $stable(op_q) && $stable(data_lines_oe_o))
    else $error("state moved during suspended clock");

  a_select_decode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && !in_adv && !selected |=> !op_q)
    else $error("access started while not selected");

  a_burst_load: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && !in_adv |=> step_q == 2'h0 && acc_addr_q == $past(in_addr) && seed_q == $past(in_addr[1:0]))
    else $error("load did not take address and seed");

  a_burst_linear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && in_adv && !in_order |=> acc_addr_q[1:0] == 2'($past(seed_q) + $past(step_q) + 2'h1))
    else $error("linear burst address wrong");

  a_burst_interleave: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && in_adv && in_order |=> acc_addr_q[1:0] == ($past(seed_q) ^ 2'($past(step_q) + 2'h1)))
    else $error("interleaved burst address wrong");

  a_write_no_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && op_q && wr_q |=> !data_lines_oe_o && !parity_lines_oe_o)
    else $error("outputs driven in write data phase");

  // the first clock after a fresh load still sees the deselected op_q, so this covers both cases
  a_desel_no_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && !op_q |=> !data_lines_oe_o && !parity_lines_oe_o)
    else $error("outputs driven while deselected");

  a_read_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && op_q && !wr_q && !in_odrv_n && !in_sleep |=> data_lines_oe_o && parity_lines_oe_o)
    else $error("read data not driven");

  a_self_timed: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (push_en && wbuf_ready && !wbuf_valid) ##1 !in_sleep |-> mem_we && wq_addr == $past(acc_addr_q))
    else $error("buffered write not retired");

  a_sleep_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    run && in_sleep |-> !mem_we ##1 (!data_lines_oe_o && !parity_lines_oe_o))
    else $error("activity during sleep");
endmodule : fts_sram_ctrl

`default_nettype wire

// ### tb/fts_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// memory controller side: one pin cycle per call, pins change at the falling edge
module fts_ctrl_model
  import fts_pkg::*;
(
  input  wire logic              clk_sys_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   select_a_n_o,
  output logic                   select_b_o,
  output logic                   select_c_n_o,
  output logic                   write_strobe_n_o,
  output logic      [LANES-1:0]  lane_write_n_o,
  output logic                   advance_or_load_o,
  output logic                   clock_qualify_n_o,
  output logic                   output_drive_n_o,
  output logic                   sleep_request_o,
  output logic                   burst_order_o,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic      [LANES-1:0]  parity_lines_o
);
  initial begin
    {addr_o, select_b_o, advance_or_load_o, clock_qualify_n_o, output_drive_n_o} = '0;
    {sleep_request_o, burst_order_o, data_lines_o, parity_lines_o} = '0;
    {select_a_n_o, select_c_n_o, write_strobe_n_o, lane_write_n_o} = '1;
  end

  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [2:0] s, input logic w,
                     input logic [LANES-1:0] l, input logic v, input logic dv, input logic [WORD_W-1:0] d);
    addr_o = a;
    {select_a_n_o, select_b_o, select_c_n_o} = s;
    write_strobe_n_o = w;
    lane_write_n_o = l;
    // v low loads a new access and v high advances the burst; the burst, suspend and write burst tests advance
    advance_or_load_o = v;
    // a released bus flips so that stale data never passes for good data
    {parity_lines_o, data_lines_o} = dv ? d : ~{parity_lines_o, data_lines_o};
    @(negedge clk_sys_i);
  endtask : cyc
endmodule : fts_ctrl_model
`default_nettype wire

// ### tb/fts_sram_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench top
module fts_sram_ctrl_tb_top
  import fts_pkg::*;
;
  localparam logic [2:0]        SEL = 3'b010;
  localparam logic [2:0]        DES = 3'b101;
  localparam logic [ADDR_W-1:0] A   = 17'h01234;
  localparam logic [ADDR_W-1:0] B   = 17'h05678;
  localparam logic [ADDR_W-1:0] W   = 17'h00100;
  logic              clk_sys_i = 1'b0;
  logic              nrst_i    = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              sa_n, sb, sc_n, wstb_n, adv, cq_n, odrv_n, sleep, order, oe, poe, wbr;
  logic [LANES-1:0]  lane_n, mpar, rpar;
  logic [DATA_W-1:0] mdat, rdat;
  logic [WORD_W-1:0] bus;
  int                n_errors = 0;
  int                compares = 0;

  always #50 clk_sys_i = ~clk_sys_i;
  // shared wire: the sram side wins while oe is high, otherwise the model drives
  assign bus = oe ? {rpar, rdat} : {mpar, mdat};

  fts_ctrl_model fts_ctrl_model_i (
    .clk_sys_i(clk_sys_i), .addr_o(addr), .select_a_n_o(sa_n), .select_b_o(sb), .select_c_n_o(sc_n),
    .write_strobe_n_o(wstb_n), .lane_write_n_o(lane_n), .advance_or_load_o(adv),
    .clock_qualify_n_o(cq_n), .output_drive_n_o(odrv_n), .sleep_request_o(sleep),
    .burst_order_o(order), .data_lines_o(mdat), .parity_lines_o(mpar));

  fts_sram_ctrl fts_sram_ctrl_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr), .select_a_n_i(sa_n), .select_b_i(sb),
    .select_c_n_i(sc_n), .write_strobe_n_i(wstb_n), .lane_write_n_i(lane_n), .advance_or_load_i(adv),
    .clock_qualify_n_i(cq_n), .output_drive_n_i(odrv_n), .sleep_request_i(sleep),
    .burst_order_i(order), .data_lines_i(bus[31:0]), .data_lines_o(rdat), .data_lines_oe_o(oe),
    .parity_lines_i(bus[35:32]), .parity_lines_o(rpar), .parity_lines_oe_o(poe),
    .write_buffer_ready_o(wbr));

  task automatic pc(input logic [ADDR_W-1:0] a, input logic [2:0] s, input logic w,
                    input logic [3:0] l, input logic v, input logic dv, input logic [35:0] d);
    fts_ctrl_model_i.cyc(a, s, w, l, v, dv, d);
  endtask : pc

  task automatic idle(input int n);
    repeat (n) pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b0, '0);
  endtask : idle

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [2:0] s);
    pc(a, s, 1'b1, 4'hF, 1'b0, 1'b0, '0);
  endtask : rd

  function automatic logic [35:0] wv(input logic [1:0] i);
    return 36'h5C0DE0000 | {34'h0, i};
  endfunction : wv

  task automatic chkw(input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chkw

  task automatic chko(input logic e);
    chkw({35'h0, e}, {35'h0, oe});
    chkw({35'h0, e}, {35'h0, poe});
  endtask : chko

  task automatic t_rw();
    pc(A, SEL, 1'b0, 4'h0, 1'b0, 1'b0, '0);
    pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b1, 36'hA11223344);
    idle(4);
    pc(A, SEL, 1'b0, 4'b1010, 1'b0, 1'b0, '0);
    pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b1, 36'h555667788);
    idle(4);
    rd(A, SEL);
    pc(B, SEL, 1'b0, 4'h0, 1'b0, 1'b0, '0);
    pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b1, 36'h00F0F0F0F);
    idle(1);
    chkw(36'hF11663388, {rpar, rdat});
    chko(1'b1);
    idle(1);
    chko(1'b0);
    idle(2);
    rd(B, SEL);
    idle(3);
    chkw(36'h00F0F0F0F, {rpar, rdat});
    $display("test rw done");
  endtask : t_rw

  task automatic burst(input logic o, input logic [1:0] s);
    fts_ctrl_model_i.burst_order_o = o;
    idle(3);
    rd({W[16:2], s}, SEL);
    repeat (3) pc(W, SEL, 1'b1, 4'hF, 1'b1, 1'b0, '0);
    for (int k = 0; k < 4; k++) begin
      chkw(wv(o ? s ^ 2'(k) : s + 2'(k)), {rpar, rdat});
      idle(1);
    end
  endtask : burst

  task automatic t_burst();
    for (int i = 0; i < 4; i++) begin
      pc({W[16:2], 2'(i)}, SEL, 1'b0, 4'h0, 1'b0, i > 0, wv(2'(i - 1)));
    end
    pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b1, wv(2'd3));
    burst(1'b0, 2'd2);
    burst(1'b1, 2'd1);
    fts_ctrl_model_i.burst_order_o = 1'b0;
    $display("test burst done");
  endtask : t_burst

  task automatic t_wburst();
    pc(B, SEL, 1'b0, 4'h0, 1'b0, 1'b0, '0);
    for (int k = 0; k < 3; k++) begin
      pc(B, SEL, 1'b0, 4'h0, 1'b1, 1'b1, wv(2'(k)));
    end
    pc('0, DES, 1'b1, 4'hF, 1'b0, 1'b1, wv(2'd3));
    idle(3);
    rd({B[16:2], 2'd1}, SEL);
    idle(3);
    chkw(wv(2'd1), {rpar, rdat});
    $display("test write burst done");
  endtask : t_wburst

  task automatic t_sel();
    logic [2:0] sv [4] = '{3'b010, 3'b110, 3'b000, 3'b011};
    for (int i = 0; i < 4; i++) begin
      rd(W, sv[i]);
      idle(3);
      chko(i == 0);
    end
    $display("test sel done");
  endtask : t_sel

  task automatic t_susp();
    idle(3);
    rd(W, SEL);
    pc(W, SEL, 1'b1, 4'hF, 1'b1, 1'b0, '0);
    fts_ctrl_model_i.clock_qualify_n_o = 1'b1;
    repeat (3) pc(W, SEL, 1'b1, 4'hF, 1'b1, 1'b0, '0);
    fts_ctrl_model_i.clock_qualify_n_o = 1'b0;
    pc(W, SEL, 1'b1, 4'hF, 1'b1, 1'b0, '0);
    idle(1);
    chko(1'b1);
    idle(2);
    chkw(wv(2'd2), {rpar, rdat});
    $display("test suspend done");
  endtask : t_susp

  task automatic t_odrv_sleep();
    fts_ctrl_model_i.output_drive_n_o = 1'b1;
    idle(2);
    rd(W, SEL);
    idle(3);
    chko(1'b0);
    fts_ctrl_model_i.output_drive_n_o = 1'b0;
    fts_ctrl_model_i.sleep_request_o = 1'b1;
    idle(2);
    rd(W, SEL);
    idle(3);
    chko(1'b0);
    fts_ctrl_model_i.sleep_request_o = 1'b0;
    idle(3);
    rd({W[16:2], 2'd3}, SEL);
    idle(3);
    chkw(wv(2'd3), {rpar, rdat});
    $display("test drive and sleep done");
  endtask : t_odrv_sleep

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    idle(3);
    chko(1'b0);
    chkw(36'h1, {35'h0, wbr});
    t_rw();
    t_burst();
    t_wburst();
    t_sel();
    t_susp();
    t_odrv_sleep();
    complete_run();
  end

  // whole run is about 120 cycles
  initial begin
    #(100 * 3000);
    n_errors++;
    complete_run();
  end
endmodule : fts_sram_ctrl_tb_top
`default_nettype wire
